/* common/aoc_params.svh */
`ifndef AOC_PARAMS_SVH
`define AOC_PARAMS_SVH

// ==========================================================
// register offsets
`define AOC_ADDR_CTL0     8'hD6
`define AOC_ADDR_CTL1     8'hD7
`define AOC_ADDR_RES_LO   8'hC0
`define AOC_ADDR_RES_HI   8'hC1

// ==========================================================
// reset values and field positions
`define AOC_CTL0_RESET    8'h00
`define AOC_CTL1_RESET    8'h00
`define AOC_CTL1_MASK     8'h38
`define AOC_B_GO          6
`define AOC_RES_HI_LSB    8

// ==========================================================
// conversion timing in conversion-clock ticks
`define AOC_CONV8_TICKS   49
`define AOC_CONV10_TICKS  59
`define AOC_BIT_TICKS     4
`define AOC_RES8_BITS     8
`define AOC_RES10_BITS    10

`endif

/* common/aoc_pkg.sv */
package aoc_pkg;

  typedef logic [7:0] aoc_byte_t;
  typedef logic [7:0] aoc_addr_t;
  typedef logic [3:0] aoc_chan_t;
  typedef logic [9:0] aoc_code_t;

  // control register 0, b7 down to b0
  typedef struct packed {
    logic       clk_sel0;
    logic       go;
    logic       auto_trig;
    logic       grp;
    logic       mode;
    logic [2:0] ch;
  } aoc_ctl0_t;

  // control register 1, b7 down to b0
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic       ref_conn;
    logic       clk_sel1;
    logic       res10;
    logic [2:0] rsv_lo;
  } aoc_ctl1_t;

  typedef enum logic [1:0] {
    AOC_CK_DIV4 = 2'h0,
    AOC_CK_DIV2 = 2'h1,
    AOC_CK_DIV1 = 2'h2,
    AOC_CK_OSC  = 2'h3
  } aoc_cks_t;

  typedef enum logic [2:0] {
    AOC_IDLE = 3'h1,
    AOC_SAMP = 3'h2,
    AOC_CONV = 3'h4
  } aoc_state_t;

endpackage

/* core/aoc_clk_div.sv */
`timescale 1ns/1ps
`default_nettype none

module aoc_clk_div
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire aoc_pkg::aoc_cks_t sel,
  input  wire logic              osc_tick,
  output var  logic              tick
);
  import aoc_pkg::*;

  logic [1:0] div_q;
  logic [1:0] div_d;
  logic       tick_q;
  logic       tick_d;

  // ==========================================================
  // conversion clock select
  always_comb
  begin
    div_d = 2'(div_q + 2'h1);
    tick_d = 1'b0;
    unique case (sel)
      AOC_CK_DIV4: tick_d = (div_q == 2'h3);
      AOC_CK_DIV2: tick_d = div_q[0];
      AOC_CK_DIV1: tick_d = 1'b1;
      AOC_CK_OSC:  tick_d = osc_tick;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_q  <= 2'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

`default_nettype wire

/* core/aoc_core.sv */
// Functional notes
// - one-shot mode converts selected input once
// - software start by writing go flag 1
// - timer event starts conversion while go set
// - software mode clears go on completion
// - writing go 0 stops running conversion
// - completion pulses the interrupt request
// - channel code plus group picks input
// - mode bit 0 selects one-shot mode
// - clock select bits pick conversion clock
// - resolution bit chooses 8 or 10 bits
// - reference connect bit must be set
// - every completed result is stored readable
`timescale 1ns/1ps
`default_nettype none

`include "aoc_params.svh"

module aoc_core
(
  input  wire logic               SYS_CLK,
  input  wire logic               RST,
  input  wire aoc_pkg::aoc_addr_t ADDR,
  input  wire aoc_pkg::aoc_byte_t WDATA,
  input  wire logic               WR_STB,
  input  wire logic               RD_STB,
  output var  aoc_pkg::aoc_byte_t RD_DATA,
  input  wire logic               TRIG_CMP_A0,
  input  wire logic               TRIG_UFL_1,
  input  wire logic               OSC_TICK,
  input  wire logic               COMP_IN,
  output var  aoc_pkg::aoc_chan_t CHANNEL,
  output var  logic               SAMPLE,
  output var  aoc_pkg::aoc_code_t DAC_CODE,
  output var  logic               REF_CONNECT,
  output var  logic               RES_10BIT,
  output var  logic               BUSY,
  output var  logic               CONV_IRQ
);
  import aoc_pkg::*;

  localparam logic [5:0] SAMP8_LOAD =
    6'(`AOC_CONV8_TICKS - `AOC_RES8_BITS * `AOC_BIT_TICKS - 1);
  localparam logic [5:0] SAMP10_LOAD =
    6'(`AOC_CONV10_TICKS - `AOC_RES10_BITS * `AOC_BIT_TICKS - 1);
  localparam logic [5:0] BIT_LOAD = 6'(`AOC_BIT_TICKS - 1);
  localparam logic [3:0] TOP8  = 4'(`AOC_RES8_BITS - 1);
  localparam logic [3:0] TOP10 = 4'(`AOC_RES10_BITS - 1);

  // ==========================================================
  // declarations
  aoc_ctl0_t  ctl0_q;
  aoc_ctl0_t  ctl0_d;
  aoc_ctl1_t  ctl1_q;
  aoc_ctl1_t  ctl1_d;
  aoc_byte_t  rd_q;
  aoc_byte_t  rd_d;
  aoc_chan_t  chan_q;
  aoc_chan_t  chan_d;

  aoc_state_t state_q;
  aoc_state_t state_d;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  aoc_code_t  code_q;
  aoc_code_t  code_d;
  aoc_code_t  res_q;
  aoc_code_t  res_d;
  logic       res10_q;
  logic       res10_d;
  logic       irq_q;
  logic       irq_d;
  logic       samp_q;
  logic       samp_d;
  logic       busy_q;
  logic       busy_d;

  logic       wr_ctl0;
  logic       wr_ctl1;
  logic       trig;
  logic       start;
  logic       abort;
  logic       done;
  logic       tick;
  aoc_cks_t   cks;

  // ==========================================================
  // conversion clock
  assign cks = aoc_cks_t'({ctl1_q.clk_sel1, ctl0_q.clk_sel0});

  aoc_clk_div u_clk_div
  (
    .clk      (SYS_CLK),
    .rst      (RST),
    .sel      (cks),
    .osc_tick (OSC_TICK),
    .tick     (tick)
  );

  // ==========================================================
  // start and stop conditions
  assign wr_ctl0 = WR_STB && (ADDR == `AOC_ADDR_CTL0);
  assign wr_ctl1 = WR_STB && (ADDR == `AOC_ADDR_CTL1);
  assign trig    = TRIG_CMP_A0 || TRIG_UFL_1;

  // no reference holds the start off, go stays set
  always_comb
  begin
    start = (state_q == AOC_IDLE) && ctl0_q.go
            && !ctl0_q.mode
            && ctl1_q.ref_conn;
    if (ctl0_q.auto_trig)
      start = start && trig;
  end

  assign abort = wr_ctl0 && !WDATA[`AOC_B_GO];

  // ==========================================================
  // register file and read port
  always_comb
  begin
    ctl0_d = ctl0_q;
    ctl1_d = ctl1_q;
    rd_d   = 8'h00;
    if (wr_ctl0)
      ctl0_d = aoc_ctl0_t'(WDATA);
    if (wr_ctl1)
      ctl1_d = aoc_ctl1_t'(WDATA & `AOC_CTL1_MASK);
    // a write in the same cycle wins over the clear
    if (done && !ctl0_q.auto_trig && !wr_ctl0)
      ctl0_d.go = 1'b0;
    // timer mode leaves go untouched here
    if (RD_STB)
    begin
      unique case (ADDR)
        `AOC_ADDR_CTL0:   rd_d = aoc_byte_t'(ctl0_q);
        `AOC_ADDR_CTL1:   rd_d = aoc_byte_t'(ctl1_q);
        `AOC_ADDR_RES_LO: rd_d = res_q[7:0];
        `AOC_ADDR_RES_HI: rd_d = {6'h00, res_q[9:8]};
        default:          rd_d = 8'h00;
      endcase
    end

    // group 1 maps codes 4..7 onto inputs 8..11
    if (ctl0_q.grp)
      chan_d = 4'({1'b0, ctl0_q.ch} + 4'h4);
    else
      chan_d = {1'b0, ctl0_q.ch};
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      ctl0_q <= aoc_ctl0_t'(`AOC_CTL0_RESET);
      ctl1_q <= aoc_ctl1_t'(`AOC_CTL1_RESET);
      rd_q   <= 8'h00;
      chan_q <= 4'h0;
    end
    else
    begin
      ctl0_q <= ctl0_d;
      ctl1_q <= ctl1_d;
      rd_q   <= rd_d;
      chan_q <= chan_d;
    end
  end

  // ==========================================================
  // successive approximation sequencer
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    bit_d   = bit_q;
    code_d  = code_q;
    res_d   = res_q;
    res10_d = res10_q;
    irq_d   = 1'b0;
    done    = 1'b0;
    unique case (state_q)
      AOC_IDLE:
      begin
        if (start)
        begin
          state_d = AOC_SAMP;
          // width latched so a later write cannot mix it
          res10_d = ctl1_q.res10;
          cnt_d   = ctl1_q.res10 ? SAMP10_LOAD : SAMP8_LOAD;
          code_d  = 10'h000;
        end
      end
      AOC_SAMP:
      begin
        if (abort)
          state_d = AOC_IDLE;
        else if (tick)
        begin
          if (cnt_q == 6'h00)
          begin
            state_d = AOC_CONV;
            bit_d   = res10_q ? TOP10 : TOP8;
            code_d  = 10'h000;
            code_d[bit_d] = 1'b1;
            cnt_d   = BIT_LOAD;
          end
          else
            cnt_d = 6'(cnt_q - 6'h01);
        end
      end
      AOC_CONV:
      begin
        if (abort)
        begin
          state_d = AOC_IDLE;
          code_d  = 10'h000;
          // stored result is kept on a stop
        end
        else if (tick)
        begin
          if (cnt_q == 6'h00)
          begin
            // keep trial bit while input is at or above it
            code_d[bit_q] = COMP_IN;
            if (bit_q == 4'h0)
            begin
              state_d = AOC_IDLE;
              res_d   = code_d;
              irq_d   = 1'b1;
              done    = 1'b1;
              code_d  = 10'h000;
            end
            else
            begin
              bit_d = 4'(bit_q - 4'h1);
              code_d[bit_d] = 1'b1;
              cnt_d = BIT_LOAD;
            end
          end
          else
            cnt_d = 6'(cnt_q - 6'h01);
        end
      end
      default:
      begin
        state_d = AOC_IDLE;
        code_d  = 10'h000;
      end
    endcase
    samp_d = (state_d == AOC_SAMP);
    busy_d = (state_d != AOC_IDLE);
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= AOC_IDLE;
      cnt_q   <= 6'h00;
      bit_q   <= 4'h0;
      code_q  <= 10'h000;
      res_q   <= 10'h000;
      res10_q <= 1'b0;
      irq_q   <= 1'b0;
      samp_q  <= 1'b0;
      busy_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      bit_q   <= bit_d;
      code_q  <= code_d;
      res_q   <= res_d;
      res10_q <= res10_d;
      irq_q   <= irq_d;
      samp_q  <= samp_d;
      busy_q  <= busy_d;
    end
  end

  // ==========================================================
  // outputs
  assign RD_DATA     = rd_q;
  assign CHANNEL     = chan_q;
  assign SAMPLE      = samp_q;
  assign DAC_CODE    = code_q;
  assign REF_CONNECT = ctl1_q.ref_conn;
  assign RES_10BIT   = ctl1_q.res10;
  assign BUSY        = busy_q;
  assign CONV_IRQ    = irq_q;

endmodule

`default_nettype wire

/* tb/aoc_far_model.sv */
`timescale 1ns/1ps
`default_nettype none

module aoc_far_model
(
  input  wire logic       clk,
  input  wire logic [3:0] chan,
  input  wire logic [9:0] code,
  input  wire logic       res10,
  input  wire logic       busy,
  input  wire logic [9:0] salt,
  output var  logic       comp
);
  logic [9:0] lvl;
  logic       tgl = 1'b0;
  // per-input level, distinct for each channel
  assign lvl = salt + {chan, 6'h00};
  always @(posedge clk) tgl <= ~tgl;
  // comparator; wobbles while nobody converts
  always_comb comp = !busy ? tgl : res10 ? lvl >= code
                                         : lvl[9:2] >= code[7:0];
endmodule

`default_nettype wire

/* tb/aoc_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module aoc_checker
(
  input wire logic               SYS_CLK,
  input wire logic               RST,
  input wire aoc_pkg::aoc_addr_t ADDR,
  input wire logic               RD_STB,
  input wire aoc_pkg::aoc_byte_t RD_DATA,
  input wire aoc_pkg::aoc_chan_t CHANNEL,
  input wire logic               SAMPLE,
  input wire aoc_pkg::aoc_code_t DAC_CODE,
  input wire logic               REF_CONNECT,
  input wire logic               RES_10BIT,
  input wire logic               BUSY,
  input wire logic               CONV_IRQ
);
  import aoc_pkg::*;
  logic [9:0] run_q;
  logic [9:0] run_d;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  always_comb run_d = BUSY ? run_q + 10'h001 : 10'h000;
  always_ff @(posedge SYS_CLK or posedge RST)
    if (RST) run_q <= 10'h000;
    else run_q <= run_d;
  sequence conv_end_s;
    CONV_IRQ && !BUSY;
  endsequence
  irq_pulse_a: assert property (CONV_IRQ |=> !CONV_IRQ)
    else $error("irq longer than one cycle");
  irq_busy_a: assert property (CONV_IRQ |-> conv_end_s and $past(BUSY))
    else $error("irq not at end of conversion");
  conv_len_a: assert property (CONV_IRQ |->
    run_q >= (RES_10BIT ? 10'h03A : 10'h030))
    else $error("conversion too short");
  idle_code_a: assert property (!BUSY |-> DAC_CODE == 10'h000)
    else $error("trial code while idle");
  rd_quiet_a: assert property (!$past(RD_STB) |-> RD_DATA == 8'h00)
    else $error("read data without read");
  rsv_zero_a: assert property ($past(RD_STB) && $past(ADDR) == 8'hD7
    |-> (RD_DATA & 8'hC7) == 8'h00)
    else $error("reserved bits not zero");
  ref_start_a: assert property ($rose(BUSY) |-> REF_CONNECT && SAMPLE)
    else $error("start without reference");
  msb_trial_a: assert property ($fell(SAMPLE) && BUSY |->
    DAC_CODE == (RES_10BIT ? 10'h200 : 10'h080))
    else $error("first trial code wrong");
  chan_max_a: assert property (CHANNEL <= 4'hB)
    else $error("channel out of range");
  chan_map_a: assert property ($past(RD_STB) && $past(ADDR) == 8'hD6
    |-> CHANNEL == {1'b0, RD_DATA[2:0]} + {1'b0, RD_DATA[4], 2'h0})
    else $error("channel not mapped from control 0");
endmodule

bind aoc_core aoc_checker u_chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .RD_STB(RD_STB),
  .RD_DATA(RD_DATA), .CHANNEL(CHANNEL), .SAMPLE(SAMPLE),
  .DAC_CODE(DAC_CODE), .REF_CONNECT(REF_CONNECT),
  .RES_10BIT(RES_10BIT), .BUSY(BUSY), .CONV_IRQ(CONV_IRQ));

`default_nettype wire

/* tb/aoc_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module aoc_core_tb;
  import aoc_pkg::*;
  logic      clk = 1'b0, rst, wr = 1'b0, rd = 1'b0;
  logic      ta = 1'b0, tu = 1'b0, osc = 1'b0;
  logic      comp, sam, refc, r10, busy, irq, gi;
  aoc_addr_t addr = 8'h00;
  aoc_byte_t wd = 8'h00, rdat, got;
  aoc_chan_t chan;
  aoc_code_t code, last, salt = 10'h000;
  int        err_total = 0, n_tests = 0, cyc = 0, i;
  int        seed = 32'h48EB1576;

  aoc_core dut (
    .SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wd),
    .WR_STB(wr), .RD_STB(rd), .RD_DATA(rdat), .TRIG_CMP_A0(ta),
    .TRIG_UFL_1(tu), .OSC_TICK(osc), .COMP_IN(comp), .CHANNEL(chan),
    .SAMPLE(sam), .DAC_CODE(code), .REF_CONNECT(refc),
    .RES_10BIT(r10), .BUSY(busy), .CONV_IRQ(irq));
  aoc_far_model far (.clk(clk), .chan(chan), .code(code), .res10(r10),
    .busy(busy), .salt(salt), .comp(comp));

  initial forever #4 clk = ~clk;
  always @(posedge clk) osc <= ($random(seed) % 3) == 0;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test;
    end
  end

  // ====================
  // tasks
  task automatic finish_test;
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(string s, logic [9:0] e, logic [9:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr_reg(aoc_addr_t a, aoc_byte_t d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(aoc_addr_t a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdat;
  endtask
  task automatic wait_irq;
    gi = 1'b0;
    for (int k = 0; k < 1000 && !gi; k++)
    begin
      @(posedge clk);
      #1 gi = irq;
    end
  endtask
  task automatic trig(logic u);
    @(posedge clk);
    if (u) tu <= 1'b1;
    else ta <= 1'b1;
    @(posedge clk);
    ta <= 1'b0;
    tu <= 1'b0;
  endtask
  function automatic aoc_code_t exp_res(aoc_chan_t c, logic r);
    aoc_code_t l;
    l = salt + {c, 6'h00};
    exp_res = r ? l : {2'h0, l[9:2]};
  endfunction
  task automatic conv(logic [2:0] ch, logic g, logic r, logic [1:0] k);
    aoc_chan_t c;
    c = {1'b0, ch} + (g ? 4'h4 : 4'h0);
    salt <= $random(seed);
    wr_reg(8'hD7, {2'h0, 1'b1, k[1], r, 3'h0});
    wr_reg(8'hD6, {k[0], 2'h2, g, 1'b0, ch});
    wait_irq;
    chk("irq", 1, gi);
    chk("channel", c, chan);
    rd_reg(8'hC0);
    last[7:0] = got;
    rd_reg(8'hC1);
    last[9:8] = got[1:0];
    chk("result", exp_res(c, r), last);
    rd_reg(8'hD6);
    chk("go flag", 0, got[6]);
  endtask

  // ====================
  // sequence
  initial
  begin
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'hD6);
    chk("ctl0 reset", 0, got);
    rd_reg(8'hD7);
    chk("ctl1 reset", 0, got);
    rd_reg(8'h10);
    chk("unmapped", 0, got);
    wr_reg(8'hD7, 8'hFF);
    rd_reg(8'hD7);
    chk("ctl1 read", 8'h38, got);
    for (i = 0; i < 12; i++)
      conv(i > 7 ? i - 4 : i, i > 7, $random(seed), i);
    wr_reg(8'hD6, 8'h41);
    repeat (20) @(posedge clk);
    wr_reg(8'hD6, 8'h01);
    #1 chk("abort busy", 0, busy);
    wait_irq;
    chk("abort irq", 0, gi);
    rd_reg(8'hC0);
    chk("abort result", last[7:0], got);
    wr_reg(8'hD6, 8'h60);
    wait_irq;
    chk("timer idle", 0, gi);
    trig(1'b0);
    wait_irq;
    chk("cmp start", 1, gi);
    rd_reg(8'hD6);
    chk("go kept", 1, got[6]);
    trig(1'b1);
    wait_irq;
    chk("ufl start", 1, gi);
    wr_reg(8'hD6, 8'h00);
    wr_reg(8'hD7, 8'h00);
    wr_reg(8'hD6, 8'h40);
    wait_irq;
    chk("no ref", 0, gi);
    wr_reg(8'hD7, 8'h20);
    wait_irq;
    chk("ref start", 1, gi);
    wr_reg(8'hD6, 8'h48);
    wait_irq;
    chk("repeat mode", 0, gi);
    finish_test;
  end
endmodule

`default_nettype wire
